// ---- rtl/pwr_clk_pkg.sv ----
// Package: register map, field positions and types of the power/clock block
package pwr_clk_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// Register indices; the byte address is the index itself on this port
	localparam logic [7:0] ADDR_POWER      = 8'h31;
	localparam logic [7:0] ADDR_OSC        = 8'h32;
	localparam logic [7:0] ADDR_EXCITATION = 8'h33;
	localparam logic [7:0] ADDR_TMR_CFG    = 8'h34;

	// Power register fields
	localparam int PWR_FLASH_BIT = 12;
	localparam int PWR_ADC_BIT   = 8;
	localparam int PWR_DAC2_BIT  = 5;
	localparam int PWR_DAC1_BIT  = 4;
	localparam int PWR_AMP2_BIT  = 1;
	localparam int PWR_AMP1_BIT  = 0;
	localparam logic [15:0] PWR_MASK = 16'h1133;

	// Oscillator register fields
	localparam int OSC_TRIM_LSB = 8;
	localparam int OSC_TRIM_W   = 5;
	localparam int OSC_CKOUT_BIT = 0;
	localparam logic [15:0] OSC_MASK = 16'h1f01;

	// Excitation register field
	localparam int EXC_W = 3;
	localparam logic [15:0] EXC_MASK = 16'h0007;

	// Timer configuration: prescale code in upper nibble
	localparam int PS_LSB = 12;
	localparam int PS_W   = 4;
	localparam logic [15:0] TMR_CFG_MASK = 16'hffff;

	// Excitation step in microamps
	localparam logic [10:0] EXC_STEP_UA = 11'h0a7;

	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] READ_ZERO = 16'h0000;

	localparam int DIV_W = 9;

	typedef struct packed {
		logic flash_program_power;
		logic converter_in_power;
		logic chan2_converter_power;
		logic chan1_converter_power;
		logic chan2_amp_power;
		logic chan1_amp_power;
	} power_ctl_t;

	typedef struct packed {
		logic chan2_amp_on;
		logic chan1_amp_on;
		logic chan2_amp_buffer;
		logic chan1_amp_buffer;
	} amp_state_t;

	typedef enum logic [1:0] {
		CLK_EXTERNAL,
		CLK_INTERNAL_QUIET,
		CLK_INTERNAL_DRIVE
	} clk_mode_t;

endpackage : pwr_clk_pkg

// ---- rtl/prescale_decode.sv ----
// Prescaler code to divide ratio decoder
`timescale 1ns/1ps
`default_nettype none
module prescale_decode
	import pwr_clk_pkg::*;
(
	// Code in
	input  wire logic [PS_W-1:0]  prescale_code,
	// Ratio out
	output logic      [DIV_W-1:0] divide_ratio
);
	logic [DIV_W-1:0] pow2;

	always_comb begin
		pow2 = DIV_W'(1) << prescale_code[PS_W-1:1];
		if (prescale_code[0]) begin
			divide_ratio = DIV_W'(pow2 + (pow2 << 1)); // [RQ2]
		end else begin
			divide_ratio = pow2; // [RQ1]
		end
	end
endmodule : prescale_decode
`default_nettype wire

// ---- rtl/amp_override.sv ----
// Amplifier power and buffer override for one output channel
`timescale 1ns/1ps
`default_nettype none
module amp_override (
	// Controls
	input  wire logic converter_power,
	input  wire logic amp_power_bit,
	input  wire logic amp_buffer_mode,
	// Effective state
	output logic      amp_on,
	output logic      amp_buffer
);
	// A running converter needs its amplifier as a buffer
	assign amp_on     = converter_power | amp_power_bit; // [RQ9] [RQ10]
	assign amp_buffer = converter_power | amp_buffer_mode; // [RQ10]
endmodule : amp_override
`default_nettype wire

// ---- rtl/power_clock_current_control.sv ----
// Power enables, excitation current, oscillator trim and clock pin control
//
// Notes on behaviour
// RQ1 - Even prescale code divides by two to the upper three bits, 1 to 128.
// RQ2 - Odd prescale code divides by three times that power, 3 to 384.
// RQ3 - Prescale code is the upper nibble of the timer configuration word.
// RQ4 - Excitation register holds a 3-bit level in bits 2..0.
// RQ5 - Excitation level maps to 167 uA steps; zero switches source off.
// RQ6 - Power bit 12 enables flash program and erase power.
// RQ7 - Power bit 8 enables converter input (ADC) power.
// RQ8 - Power bits 5 and 4 power channel two and one output converters.
// RQ9 - Power bits 1 and 0 power channel amplifiers; off means high impedance.
// RQ10 - Enabled converter forces its amplifiers on and in buffer mode.
// RQ11 - Oscillator trim is a 5-bit two's-complement field, bits 12..8.
// RQ12 - Trim zero is nominal; positive raises, negative lowers frequency.
// RQ13 - Oscillator bit 0 enables driving internal clock onto clock pin.
// RQ14 - Select pin low halts oscillator; clock pin is an input.
// RQ15 - Select pin low requires an external running clock on the pin.
// RQ16 - Select high, output off: oscillator runs, pin high impedance.
// RQ17 - Select high, output on: oscillator runs and drives the pin.
// RQ18 - Unused bits read zero; writes to them have no effect.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module power_clock_current_control
	import pwr_clk_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// Clock pin and select strap
	input  wire logic              clock_source_select_pin,
	input  wire logic              osc_clk,
	input  wire logic              clock_pin_in,
	output logic                   clock_pin_out,
	output logic                   clock_pin_oe,
	output logic                   osc_run,
	output logic                   core_clk_from_pin,
	output logic signed [OSC_TRIM_W-1:0] osc_trim,
	// Analog power controls
	output power_ctl_t             power_ctl,
	input  wire logic              chan1_buffer_bit,
	input  wire logic              chan2_buffer_bit,
	output amp_state_t             amp_state,
	// Excitation source
	output logic      [EXC_W-1:0]  excitation_level,
	output logic                   excitation_on,
	output logic      [10:0]       excitation_ua,
	// Timer prescaler
	output logic      [PS_W-1:0]   prescale_code,
	output logic      [DIV_W-1:0]  divide_ratio
);

	////////////////////////////////////////////////////////////////////////
	// Register storage

	logic [DATA_W-1:0] power_reg;
	logic [DATA_W-1:0] osc_reg;
	logic [DATA_W-1:0] exc_reg;
	logic [DATA_W-1:0] tmr_cfg_reg;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			power_reg <= REG_RESET;
		end else if (reg_wr && reg_addr == ADDR_POWER) begin
			power_reg <= reg_wdata & PWR_MASK; // [RQ18]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			osc_reg <= REG_RESET;
		end else if (reg_wr && reg_addr == ADDR_OSC) begin
			osc_reg <= reg_wdata & OSC_MASK; // [RQ18]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			exc_reg <= REG_RESET;
		end else if (reg_wr && reg_addr == ADDR_EXCITATION) begin
			exc_reg <= reg_wdata & EXC_MASK; // [RQ4] [RQ18]
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tmr_cfg_reg <= REG_RESET;
		end else if (reg_wr && reg_addr == ADDR_TMR_CFG) begin
			tmr_cfg_reg <= reg_wdata & TMR_CFG_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data one cycle after the strobe, zero otherwise

	logic [DATA_W-1:0] next_rdata;

	always_comb begin
		case (reg_addr)
			ADDR_POWER:      next_rdata = power_reg;
			ADDR_OSC:        next_rdata = osc_reg;
			ADDR_EXCITATION: next_rdata = exc_reg;
			ADDR_TMR_CFG:    next_rdata = tmr_cfg_reg;
			default:         next_rdata = READ_ZERO; // [RQ18]
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= READ_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= READ_ZERO;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power controls

	always_comb begin
		power_ctl.flash_program_power   = power_reg[PWR_FLASH_BIT]; // [RQ6]
		power_ctl.converter_in_power    = power_reg[PWR_ADC_BIT]; // [RQ7]
		power_ctl.chan2_converter_power = power_reg[PWR_DAC2_BIT]; // [RQ8]
		power_ctl.chan1_converter_power = power_reg[PWR_DAC1_BIT]; // [RQ8]
		power_ctl.chan2_amp_power       = power_reg[PWR_AMP2_BIT]; // [RQ9]
		power_ctl.chan1_amp_power       = power_reg[PWR_AMP1_BIT]; // [RQ9]
	end

	amp_override u_chan1_amp (
		.converter_power (power_reg[PWR_DAC1_BIT]),
		.amp_power_bit   (power_reg[PWR_AMP1_BIT]),
		.amp_buffer_mode (chan1_buffer_bit),
		.amp_on          (amp_state.chan1_amp_on),
		.amp_buffer      (amp_state.chan1_amp_buffer)
	);

	amp_override u_chan2_amp (
		.converter_power (power_reg[PWR_DAC2_BIT]),
		.amp_power_bit   (power_reg[PWR_AMP2_BIT]),
		.amp_buffer_mode (chan2_buffer_bit),
		.amp_on          (amp_state.chan2_amp_on),
		.amp_buffer      (amp_state.chan2_amp_buffer)
	);

	////////////////////////////////////////////////////////////////////////
	// Excitation current

	assign excitation_level = exc_reg[EXC_W-1:0]; // [RQ4]
	assign excitation_on    = |exc_reg[EXC_W-1:0]; // [RQ5]
	// Magnitude of sourced current in microamps
	assign excitation_ua    = 11'(EXC_STEP_UA * exc_reg[EXC_W-1:0]); // [RQ5]

	////////////////////////////////////////////////////////////////////////
	// Oscillator trim and clock pin

	// Analog trim takes the code as signed; ordering is monotonic
	assign osc_trim = $signed(osc_reg[OSC_TRIM_LSB +: OSC_TRIM_W]); // [RQ11] [RQ12]

	clk_mode_t clk_mode;

	always_comb begin
		if (!clock_source_select_pin) begin
			clk_mode = CLK_EXTERNAL; // [RQ14]
		end else if (osc_reg[OSC_CKOUT_BIT]) begin
			clk_mode = CLK_INTERNAL_DRIVE; // [RQ13] [RQ17]
		end else begin
			clk_mode = CLK_INTERNAL_QUIET; // [RQ16]
		end
	end

	always_comb begin
		case (clk_mode)
			CLK_EXTERNAL: begin
				// Core relies on the far side clocking the pin [RQ15]
				osc_run           = 1'b0; // [RQ14]
				clock_pin_oe      = 1'b0;
				core_clk_from_pin = 1'b1;
			end
			CLK_INTERNAL_DRIVE: begin
				osc_run           = 1'b1;
				clock_pin_oe      = 1'b1; // [RQ17]
				core_clk_from_pin = 1'b0;
			end
			CLK_INTERNAL_QUIET: begin
				osc_run           = 1'b1;
				clock_pin_oe      = 1'b0; // [RQ16]
				core_clk_from_pin = 1'b0;
			end
			default: begin
				osc_run           = 1'b1;
				clock_pin_oe      = 1'b0;
				core_clk_from_pin = 1'b0;
			end
		endcase
	end

	// Pin driver path is combinational; the oscillator is a free analog clock
	assign clock_pin_out = clock_pin_oe & osc_clk; // [RQ13]

	////////////////////////////////////////////////////////////////////////
	// Timer prescaler

	assign prescale_code = tmr_cfg_reg[PS_LSB +: PS_W]; // [RQ3]

	prescale_decode u_prescale (
		.prescale_code (tmr_cfg_reg[PS_LSB +: PS_W]),
		.divide_ratio  (divide_ratio)
	);

	// Pin input is consumed by the clock mux outside this block
	logic unused_pin_in;
	assign unused_pin_in = clock_pin_in;

endmodule : power_clock_current_control
`default_nettype wire

// ---- test/pcc_checker.sv ----
// Checker for the power, clock and current control block
`timescale 1ns/1ps
`default_nettype none
module pcc_checker
	import pwr_clk_pkg::*;
(
	// Clock, reset, register port
	input wire logic              clk_sys,
	input wire logic              rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	// Clock pin
	input wire logic              clock_source_select_pin,
	input wire logic              clock_pin_oe,
	input wire logic              osc_run,
	input wire logic              core_clk_from_pin,
	input wire logic signed [OSC_TRIM_W-1:0] osc_trim,
	// Power, excitation, prescaler
	input wire power_ctl_t        power_ctl,
	input wire amp_state_t        amp_state,
	input wire logic [EXC_W-1:0]  excitation_level,
	input wire logic              excitation_on,
	input wire logic [10:0]       excitation_ua,
	input wire logic [PS_W-1:0]   prescale_code,
	input wire logic [DIV_W-1:0]  divide_ratio
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_strap_low_input: assert property (!clock_source_select_pin |->
		!clock_pin_oe && !osc_run && core_clk_from_pin) else $error("pin in");
	a_strap_high_run: assert property (clock_source_select_pin |->
		osc_run && !core_clk_from_pin) else $error("osc stopped");
	a_pin_enable_write: assert property (reg_wr && reg_addr == ADDR_OSC
		##1 clock_source_select_pin |-> clock_pin_oe == $past(reg_wdata[0]))
		else $error("pin enable");
	a_amp_forced_on: assert property (power_ctl.chan1_converter_power |->
		amp_state.chan1_amp_on && amp_state.chan1_amp_buffer)
		else $error("amp not forced");
	a_amp_follow_bit: assert property (!power_ctl.chan2_converter_power |->
		amp_state.chan2_amp_on == power_ctl.chan2_amp_power)
		else $error("amp power");
	a_ratio_decode: assert property (divide_ratio ==
		((prescale_code[0] ? 9'h003 : 9'h001) << prescale_code[3:1]))
		else $error("ratio");
	a_exc_current: assert property (excitation_ua ==
		11'(excitation_level) * 11'h0a7 && excitation_on == |excitation_level)
		else $error("current");
	a_power_write: assert property (reg_wr && reg_addr == ADDR_POWER |=>
		{3'h0, power_ctl[5], 3'h0, power_ctl[4], 2'h0, power_ctl[3:2], 2'h0,
		power_ctl[1:0]} == $past(reg_wdata & 16'h1133)) else $error("power");
	a_exc_readback: assert property (reg_rd && reg_addr == ADDR_EXCITATION
		|=> reg_rdata == {13'h0, excitation_level}) else $error("readback");
	a_trim_write: assert property (reg_wr && reg_addr == ADDR_OSC |=>
		osc_trim == $past(reg_wdata[12:8])) else $error("trim");

	c_power: cover property (reg_wr && reg_addr == ADDR_POWER);
	c_strap_low: cover property (!clock_source_select_pin);
	c_odd_code: cover property (prescale_code[0]);
endmodule : pcc_checker

bind power_clock_current_control pcc_checker pcc_checker_i (.*);
`default_nettype wire

// ---- test/power_clock_current_control_test.sv ----
// Self-checking bench for the power, clock and current control block
`timescale 1ns/1ps
`default_nettype none
module power_clock_current_control_test import pwr_clk_pkg::*;;
	logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, osc_clk = 0;
	logic clock_source_select_pin = 1, clock_pin_in = 0;
	logic chan1_buffer_bit = 0, chan2_buffer_bit = 0;
	logic [7:0] reg_addr = 0;
	logic [15:0] reg_wdata = 0, reg_rdata;
	logic clock_pin_out, clock_pin_oe, osc_run, core_clk_from_pin;
	logic signed [4:0] osc_trim;
	power_ctl_t power_ctl;
	amp_state_t amp_state;
	logic [2:0] excitation_level;
	logic excitation_on;
	logic [10:0] excitation_ua;
	logic [3:0] prescale_code;
	logic [8:0] divide_ratio;
	int n_mismatch = 0, checks = 0;

	power_clock_current_control power_clock_current_control_i (.*);

	initial forever #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) osc_clk <= ~osc_clk;
	// Far side runs the pin clock only while the strap selects it
	always @(posedge clk_sys)
		clock_pin_in <= !clock_source_select_pin & ~clock_pin_in;

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	task automatic t_power;
		int bits[6] = '{12, 8, 5, 4, 1, 0};
		for (int i = 0; i < 6; i++) begin
			wr(ADDR_POWER, 16'h0001 << bits[i]);
			chk(power_ctl, 16'h0020 >> i);
		end
		@(posedge clk_sys);
		chan1_buffer_bit <= 1'b1;
		wr(ADDR_POWER, 16'h0003);
		chk(amp_state, 16'h000d);
		wr(ADDR_POWER, 16'h0030);
		chk(amp_state, 16'h000f);
		wr(ADDR_POWER, 16'h0000);
		chk(amp_state, 16'h0001);
		wr(ADDR_POWER, 16'hffff);
		rd(ADDR_POWER, 16'h1133);
		$display("t_power done");
	endtask : t_power

	task automatic t_exc;
		for (int l = 0; l < 8; l++) begin
			wr(ADDR_EXCITATION, 16'hfff8 | 16'(l));
			chk(excitation_ua, 16'(167 * l));
			chk(excitation_on, 16'(l != 0));
			rd(ADDR_EXCITATION, 16'(l));
		end
		$display("t_exc done");
	endtask : t_exc

	task automatic t_osc;
		logic [4:0] t;
		for (int i = 0; i < 32; i++) begin
			t = 5'(i);
			wr(ADDR_OSC, {3'h7, t, 8'hf1});
			chk({11'h0, osc_trim}, {11'h0, t});
			chk(clock_pin_oe, 16'h0001);
			chk(clock_pin_out, osc_clk);
			rd(ADDR_OSC, {3'h0, t, 8'h01});
		end
		wr(ADDR_OSC, 16'h0000);
		chk({clock_pin_oe, osc_run}, 16'h0001);
		wr(ADDR_OSC, 16'h0001);
		@(posedge clk_sys);
		clock_source_select_pin <= 1'b0;
		#1;
		chk({clock_pin_oe, osc_run, core_clk_from_pin}, 16'h0001);
		@(posedge clk_sys);
		clock_source_select_pin <= 1'b1;
		$display("t_osc done");
	endtask : t_osc

	task automatic t_prescale;
		logic [3:0] c;
		for (int i = 0; i < 16; i++) begin
			c = 4'(i);
			wr(ADDR_TMR_CFG, {c, 12'h5a5});
			chk(prescale_code, c);
			chk(divide_ratio, (c[0] ? 16'h3 : 16'h1) << c[3:1]);
			rd(ADDR_TMR_CFG, {c, 12'h5a5});
		end
		wr(8'h35, 16'hffff);
		rd(8'h35, 16'h0000);
		$display("t_prescale done");
	endtask : t_prescale

	task automatic final_report;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : final_report

	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 8'h31; a < 8'h35; a++)
			rd(8'(a), 16'h0000);
		chk(divide_ratio, 16'h0001);
		t_power;
		t_exc;
		t_osc;
		t_prescale;
		final_report;
	end

	initial begin
		#500000;
		n_mismatch++;
		final_report;
	end
endmodule : power_clock_current_control_test
`default_nettype wire
